// ### hw/itc_map.svh
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// Register byte addresses on the internal register port
`define ITC_ADDR_FILTER   16'h100E
`define ITC_ADDR_HOLD     16'h100F
`define ITC_ADDR_TMO      16'h1010

// Reset values
`define ITC_FILTER_RST    8'h88
`define ITC_HOLD_RST      8'h03
`define ITC_TMO_RST       8'hB7

// Input filter register fields
`define ITC_DF_LEN        7:5
`define ITC_DF_ON         4
`define ITC_CF_LEN        3:1
`define ITC_CF_ON         0

// Access timeout register fields
`define ITC_REFUSE        7
`define ITC_OWN_OFF       6
`define ITC_OWN_LEN       5:4
`define ITC_ACC_OFF       3
`define ITC_ACC_LEN       2:0

// Timing
`define ITC_CORE_KHZ      125000
`define ITC_OWN_BASE_MS   64
`define ITC_ACC_SHIFT     3
`define ITC_ACC_LONG_CODE 3'h7
`define ITC_ACC_LONG_CYC  65535

`endif

// ### hw/itc_pkg.sv
package itc_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_EXTEND}         itc_hold_e;
  typedef enum logic [1:0] {AC_IDLE, AC_WAIT, AC_BUSY}  itc_acc_e;
  typedef logic [7:0]                                   itc_byte_t;
endpackage : itc_pkg

// ### hw/itc_filter.sv
`timescale 1ns/1ps
// Debounce filter for one already synchronised line
module itc_filter (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       din,
  input  wire logic       on,
  input  wire logic [2:0] len,
  output logic            dout
);
  logic       dout_q, dout_d;
  logic [2:0] cnt_q, cnt_d;

  // Follow the input once it has held a new level for len cycles
  always_comb begin
    dout_d = dout_q;
    cnt_d  = 3'h0;
    if (!on || len == 3'h0) begin
      dout_d = din;
    end else if (din != dout_q) begin
      if (cnt_q == len - 3'h1) begin
        dout_d = din;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dout_q <= 1'b1;
      cnt_q  <= 3'h0;
    end else begin
      dout_q <= dout_d;
      cnt_q  <= cnt_d;
    end
  end

  assign dout = dout_q;
endmodule : itc_filter

// ### hw/itc_cond.sv
// How it works
// - The data line filter length comes from bits 7:5 of the filter register, 0 to 7, reset 4.
// - The clock line filter length comes from bits 3:1 of the filter register, 0 to 7, reset 4.
// - Data line filtering acts only while bit 4 is set; it resets to off.
// - Clock line filtering acts only while bit 0 is set; it resets to off.
// - After the target turns ready the clock line stays low for the hold extension count more.
// - With bit 7 clear, an access attempt while not bus owner holds the clock line low.
// - The ownership timeout runs while bit 6 is clear and is suppressed while it is set.
// - The per-access timeout runs while bit 3 is clear and is suppressed while it is set.
// - Bits 2:0 pick 7, 15, 31, 63, 127, 255, 511 or 65535 cycles of access timeout.
`timescale 1ns/1ps
`include "itc_map.svh"
module itc_cond #(
  parameter int unsigned OWN_BASE_CYC = `ITC_OWN_BASE_MS * `ITC_CORE_KHZ,
  parameter int unsigned ACC_LONG_CYC = `ITC_ACC_LONG_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        apb_clk,
  input  wire logic        apb_rst,
  input  wire logic        scl_pin_in,
  input  wire logic        sda_pin_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             scl_filt,
  output logic             sda_filt,
  input  wire logic        tgt_busy,
  input  wire logic        acc_req,
  output logic             nack,
  output logic             acc_done,
  output logic             acc_timeout,
  output logic             owner_timeout,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic        apb_owner,
  input  wire logic        apb_pready,
  output logic             apb_start
);
  // Per-access timeout limit in cycles
  function automatic logic [15:0] acc_limit(input logic [2:0] sel);
    if (sel == `ITC_ACC_LONG_CODE) begin
      acc_limit = ACC_LONG_CYC[15:0];
    end else begin
      acc_limit = (16'h1 << (sel + `ITC_ACC_SHIFT)) - 16'h1;
    end
  endfunction : acc_limit

  // Ownership timeout limit in cycles
  function automatic logic [26:0] own_limit(input logic [1:0] sel);
    own_limit = OWN_BASE_CYC[26:0] << sel;
  endfunction : own_limit

  itc_pkg::itc_byte_t filt_q, filt_d, hold_q, hold_d, tmo_q, tmo_d, rdata_q, rdata_d;
  logic [1:0]         scl_sync_q, sda_sync_q, own_sync_q, ack_sync_q;
  logic [1:0]         req_sync_q;
  logic               req_seen_q;
  logic               req_tgl_q, req_tgl_d, ack_tgl_q, ack_tgl_d;
  logic               busy_apb_q, busy_apb_d;
  itc_pkg::itc_hold_e hst_q, hst_d;
  logic [7:0]         ext_q, ext_d;
  itc_pkg::itc_acc_e  ast_q, ast_d;
  logic [15:0]        acnt_q, acnt_d;
  logic [26:0]        ocnt_q, ocnt_d;
  logic               oexp_q, oexp_d;
  logic               nack_q, nack_d, done_q, done_d, ato_q, ato_d, oto_q, oto_d;
  logic               owner_s, ack_back;

  // Register file
  always_comb begin
    filt_d  = filt_q;
    hold_d  = hold_q;
    tmo_d   = tmo_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      unique case (reg_addr)
        `ITC_ADDR_FILTER: filt_d = reg_wdata;
        `ITC_ADDR_HOLD:   hold_d = reg_wdata;
        `ITC_ADDR_TMO:    tmo_d  = reg_wdata;
        default:          ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ITC_ADDR_FILTER: rdata_d = filt_q;
        `ITC_ADDR_HOLD:   rdata_d = hold_q;
        `ITC_ADDR_TMO:    rdata_d = tmo_q;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_q  <= `ITC_FILTER_RST;
      hold_q  <= `ITC_HOLD_RST;
      tmo_q   <= `ITC_TMO_RST;
      rdata_q <= 8'h00;
    end else begin
      filt_q  <= filt_d;
      hold_q  <= hold_d;
      tmo_q   <= tmo_d;
      rdata_q <= rdata_d;
    end
  end

  // Two-flop synchronisers into the core domain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      own_sync_q <= 2'h0;
      ack_sync_q <= 2'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_pin_in};
      sda_sync_q <= {sda_sync_q[0], sda_pin_in};
      own_sync_q <= {own_sync_q[0], apb_owner};
      ack_sync_q <= {ack_sync_q[0], ack_tgl_q};
    end
  end
  assign owner_s  = own_sync_q[1];
  assign ack_back = (ack_sync_q[1] == req_tgl_q);

  itc_filter u_sda_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (sda_sync_q[1]),
    .on       (filt_q[`ITC_DF_ON]),
    .len      (filt_q[`ITC_DF_LEN]),
    .dout     (sda_filt)
  );

  itc_filter u_scl_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (scl_sync_q[1]),
    .on       (filt_q[`ITC_CF_ON]),
    .len      (filt_q[`ITC_CF_LEN]),
    .dout     (scl_filt)
  );

  // Hold extension after the target turns ready
  always_comb begin
    hst_d = hst_q;
    ext_d = ext_q;
    unique case (hst_q)
      itc_pkg::ST_IDLE: begin
        if (tgt_busy && hold_q != 8'h00) begin
          hst_d = itc_pkg::ST_EXTEND;
          ext_d = hold_q;
        end
      end
      itc_pkg::ST_EXTEND: begin
        // Reload while busy so the clock never lets go in the cycle busy drops
        ext_d = tgt_busy ? hold_q : ext_q - 8'h01;
        if (!tgt_busy && ext_q <= 8'h01) begin
          hst_d = itc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hst_q <= itc_pkg::ST_IDLE;
      ext_q <= 8'h00;
    end else begin
      hst_q <= hst_d;
      ext_q <= ext_d;
    end
  end

  // Access sequencing, refusal and per-access timeout
  always_comb begin
    ast_d     = ast_q;
    acnt_d    = 16'h0000;
    req_tgl_d = req_tgl_q;
    nack_d    = 1'b0;
    done_d    = 1'b0;
    ato_d     = 1'b0;
    unique case (ast_q)
      itc_pkg::AC_IDLE: begin
        if (acc_req) begin
          if (owner_s) begin
            ast_d     = itc_pkg::AC_BUSY;
            req_tgl_d = !req_tgl_q;
          end else if (tmo_q[`ITC_REFUSE]) begin
            nack_d = 1'b1;
          end else begin
            ast_d = itc_pkg::AC_WAIT;
          end
        end
      end
      itc_pkg::AC_WAIT: begin
        if (owner_s) begin
          ast_d     = itc_pkg::AC_BUSY;
          req_tgl_d = !req_tgl_q;
        end
      end
      itc_pkg::AC_BUSY: begin
        acnt_d = acnt_q + 16'h0001;
        if (ack_back) begin
          ast_d  = itc_pkg::AC_IDLE;
          done_d = 1'b1;
        end else if (!tmo_q[`ITC_ACC_OFF] &&
                     acnt_q == acc_limit(tmo_q[`ITC_ACC_LEN]) - 16'h0001) begin
          ast_d = itc_pkg::AC_IDLE;
          ato_d = 1'b1;
        end
      end
      default: ast_d = itc_pkg::AC_IDLE;
    endcase
  end

  // Ownership timeout, counted once per ownership period
  always_comb begin
    ocnt_d = 27'h0;
    oexp_d = 1'b0;
    oto_d  = 1'b0;
    if (owner_s && !tmo_q[`ITC_OWN_OFF]) begin
      oexp_d = oexp_q;
      ocnt_d = ocnt_q + 27'h1;
      if (!oexp_q && ocnt_q == own_limit(tmo_q[`ITC_OWN_LEN]) - 27'h1) begin
        oexp_d = 1'b1;
        oto_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ast_q     <= itc_pkg::AC_IDLE;
      acnt_q    <= 16'h0000;
      req_tgl_q <= 1'b0;
      ocnt_q    <= 27'h0;
      oexp_q    <= 1'b0;
      nack_q    <= 1'b0;
      done_q    <= 1'b0;
      ato_q     <= 1'b0;
      oto_q     <= 1'b0;
    end else begin
      ast_q     <= ast_d;
      acnt_q    <= acnt_d;
      req_tgl_q <= req_tgl_d;
      ocnt_q    <= ocnt_d;
      oexp_q    <= oexp_d;
      nack_q    <= nack_d;
      done_q    <= done_d;
      ato_q     <= ato_d;
      oto_q     <= oto_d;
    end
  end

  // Bus side: request toggle in, access start level out, ack toggle back
  always_comb begin
    busy_apb_d = busy_apb_q;
    ack_tgl_d  = ack_tgl_q;
    if (!busy_apb_q && req_sync_q[1] != req_seen_q) begin
      busy_apb_d = 1'b1;
    end else if (busy_apb_q && apb_pready) begin
      busy_apb_d = 1'b0;
      ack_tgl_d  = !ack_tgl_q;
    end
  end

  always_ff @(posedge apb_clk) begin
    if (apb_rst) begin
      req_sync_q <= 2'h0;
      req_seen_q <= 1'b0;
      busy_apb_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[0], req_tgl_q};
      req_seen_q <= (!busy_apb_q) ? req_sync_q[1] : req_seen_q;
      busy_apb_q <= busy_apb_d;
      ack_tgl_q  <= ack_tgl_d;
    end
  end

  // Clock line is pulled low while busy, extending or waiting for ownership
  assign scl_oe        = tgt_busy || (hst_q == itc_pkg::ST_EXTEND) ||
                         (ast_q == itc_pkg::AC_WAIT);
  assign scl_out       = 1'b0;
  assign nack          = nack_q;
  assign acc_done      = done_q;
  assign acc_timeout   = ato_q;
  assign owner_timeout = oto_q;
  assign reg_rdata     = rdata_q;
  assign apb_start     = busy_apb_q;
endmodule : itc_cond

// ### bench/itc_cond_asserts.sv
`timescale 1ns/1ps
// Port-level checks on the conditioning block
module itc_cond_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic apb_clk,
  input wire logic apb_rst,
  input wire logic sda_pin_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_filt,
  input wire logic tgt_busy,
  input wire logic acc_req,
  input wire logic nack,
  input wire logic acc_done,
  input wire logic acc_timeout,
  input wire logic owner_timeout,
  input wire logic apb_pready,
  input wire logic apb_start
);
  // Clock line pulled low and held while busy
  a_busy_hold: assert property (@(posedge core_clk) disable iff (rst)
      tgt_busy |-> scl_oe)
    else $error("clock released while busy");
  a_out_low: assert property (@(posedge core_clk) disable iff (rst)
      scl_out == 1'b0)
    else $error("clock output not low");
  // Refusal is a single pulse tied to a request; completion and both timeouts are single pulses
  a_nack_cause: assert property (@(posedge core_clk) disable iff (rst)
      nack |-> $past(acc_req) || $past(acc_req, 2))
    else $error("refusal without request");
  a_nack_once: assert property (@(posedge core_clk) disable iff (rst)
      nack |=> !nack)
    else $error("refusal too long");
  a_done_once: assert property (@(posedge core_clk) disable iff (rst)
      acc_done |=> !acc_done)
    else $error("completion too long");
  a_tmo_excl: assert property (@(posedge core_clk) disable iff (rst)
      acc_timeout |-> !acc_done ##1 !acc_timeout)
    else $error("timeout overlaps completion");
  a_own_once: assert property (@(posedge core_clk) disable iff (rst)
      owner_timeout |=> !owner_timeout)
    else $error("ownership timeout too long");
  // Filtered data only ever takes a level the pin really had
  a_filt_src: assert property (@(posedge core_clk) disable iff (rst)
      $changed(sda_filt) |->
      sda_filt == $past(sda_pin_in, 3) || sda_filt == $past(sda_pin_in, 4))
    else $error("filtered data without cause");
  a_start_hold: assert property (@(posedge apb_clk) disable iff (apb_rst)
      apb_start && !apb_pready |=> apb_start)
    else $error("access dropped before ready");
endmodule : itc_cond_asserts

// ### bench/itc_ctrl_model.sv
`timescale 1ns/1ps
// Far-side bus controller: open-drain lines with pull-ups
module itc_ctrl_model (
  input  wire logic core_clk,
  input  wire logic scl_oe,
  output logic      scl_pin_in,
  output logic      sda_pin_in
);
  logic scl_lvl = 1'b1;
  logic sda_lvl = 1'b1;
  // Wired-AND of both parties on the clock line
  assign scl_pin_in = scl_lvl & ~scl_oe;
  assign sda_pin_in = sda_lvl;
  // Pull one line low for w cycles, then release to the pull-up
  task pulse(input bit on_scl, input int w);
    @(posedge core_clk);
    if (on_scl) scl_lvl <= 1'b0;
    else sda_lvl <= 1'b0;
    repeat (w) @(posedge core_clk);
    scl_lvl <= 1'b1;
    sda_lvl <= 1'b1;
  endtask : pulse
endmodule : itc_ctrl_model

// ### bench/itc_cond_tb.sv
`timescale 1ns/1ps
`include "itc_map.svh"
module itc_cond_tb;
  logic        core_clk = 0, apb_clk = 0, rst = 1, apb_rst = 1, pr_en = 0;
  logic        tgt_busy = 0, acc_req = 0, reg_wr = 0, reg_rd = 0;
  logic        apb_owner = 0, apb_pready = 0;
  logic [15:0] reg_addr = '0;
  logic [7:0]  reg_wdata = '0;
  wire         scl_pin_in, sda_pin_in, scl_out, scl_oe, scl_filt, sda_filt;
  wire         nack, acc_done, acc_timeout, owner_timeout, apb_start;
  wire [7:0]   reg_rdata;
  wire [3:0]   ev = {owner_timeout, acc_timeout, acc_done, nack};
  int          err_count = 0, tests_run = 0, n;
  always #4 core_clk = ~core_clk;
  always #62.5 apb_clk = ~apb_clk;
  // Fabric answers one link cycle after each request while enabled
  always @(posedge apb_clk) apb_pready <= apb_start & ~apb_pready & pr_en;
  itc_cond #(.OWN_BASE_CYC(16), .ACC_LONG_CYC(40)) dut (.core_clk(core_clk), .rst(rst),
    .apb_clk(apb_clk), .apb_rst(apb_rst), .scl_pin_in(scl_pin_in), .sda_pin_in(sda_pin_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .scl_filt(scl_filt), .sda_filt(sda_filt),
    .tgt_busy(tgt_busy), .acc_req(acc_req), .nack(nack), .acc_done(acc_done),
    .acc_timeout(acc_timeout), .owner_timeout(owner_timeout), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .apb_owner(apb_owner), .apb_pready(apb_pready), .apb_start(apb_start));
  itc_ctrl_model ctl (.core_clk(core_clk), .scl_oe(scl_oe), .scl_pin_in(scl_pin_in),
    .sda_pin_in(sda_pin_in));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1 chk(reg_rdata, e);
  endtask : rdc
  // One-cycle request; release happens in the background
  task req;
    @(posedge core_clk);
    acc_req <= 1'b1;
    fork
      @(posedge core_clk) acc_req <= 1'b0;
    join_none
  endtask : req
  // Count edges until event s, giving up after b
  task wt(input int s, input int b, input bit must);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (ev[s] !== 1'b1 && n < b);
    if (must && ev[s] !== 1'b1) begin
      chk(ev[s], 1'b1);
      test_done;
    end
  endtask : wt
  // Glitch one line low for w cycles; e says whether the filter passes it
  task glt(input bit s, input int w, input bit e);
    bit lo;
    lo = 0;
    fork
      ctl.pulse(s, w);
      repeat (w + 14) begin
        @(posedge core_clk);
        #1 if ((s ? scl_filt : sda_filt) === 1'b0) lo = 1;
      end
    join
    chk(lo, e);
  endtask : glt
  // Count extra low cycles after busy drops
  task stc(input logic [7:0] h);
    int c;
    c = 0;
    wr(`ITC_ADDR_HOLD, h);
    @(posedge core_clk);
    tgt_busy <= 1'b1;
    repeat (3) @(posedge core_clk);
    tgt_busy <= 1'b0;
    #1 chk(scl_oe, h != 8'h00);
    repeat (12) begin
      if (scl_oe === 1'b1) c++;
      #8;
    end
    chk(c, h);
  endtask : stc
  initial begin
    repeat (2) @(posedge apb_clk);
    apb_rst <= 1'b0;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdc(`ITC_ADDR_FILTER, 8'h88);
    rdc(`ITC_ADDR_HOLD, 8'h03);
    rdc(`ITC_ADDR_TMO, 8'hB7);
    rdc(16'h1011, 8'h00);
    wr(`ITC_ADDR_TMO, 8'h5A);
    rdc(`ITC_ADDR_TMO, 8'h5A);
    wr(`ITC_ADDR_FILTER, 8'h99);
    glt(0, 3, 0);
    glt(0, 6, 1);
    glt(1, 3, 0);
    glt(1, 6, 1);
    wr(`ITC_ADDR_FILTER, 8'hFF);
    glt(0, 6, 0);
    glt(1, 9, 1);
    wr(`ITC_ADDR_FILTER, 8'h11);
    glt(0, 1, 1);
    glt(1, 1, 1);
    wr(`ITC_ADDR_FILTER, 8'h88);
    glt(0, 1, 1);
    glt(1, 1, 1);
    stc(8'h00);
    stc(8'h05);
    wr(`ITC_ADDR_TMO, 8'hC8);
    req;
    wt(0, 4, 1);
    chk(n <= 2, 1);
    wr(`ITC_ADDR_TMO, 8'h48);
    req;
    wt(1, 20, 0);
    chk(scl_oe, 1);
    @(posedge apb_clk) apb_owner <= 1'b1;
    pr_en <= 1'b1;
    wt(1, 400, 1);
    chk(scl_oe, 0);
    // Codes 0 and 1, then the long code with the bench's shortened limit
    for (int k = 0; k < 3; k++) begin
      int lim;
      lim = (k == 2) ? 40 : (8 << k) - 1;
      pr_en <= 1'b0;
      wr(`ITC_ADDR_TMO, (k == 2) ? 8'hC7 : (8'hC0 | 8'(k)));
      req;
      wt(2, 60, 1);
      chk(n >= lim && n <= lim + 4, 1);
      pr_en <= 1'b1;
      repeat (80) @(posedge core_clk);
    end
    pr_en <= 1'b0;
    wr(`ITC_ADDR_TMO, 8'hC8);
    req;
    wt(2, 100, 0);
    chk(n, 100);
    pr_en <= 1'b1;
    wt(1, 400, 1);
    wr(`ITC_ADDR_TMO, 8'h88);
    wt(3, 40, 1);
    chk(n >= 14 && n <= 22, 1);
    @(posedge apb_clk) apb_owner <= 1'b0;
    wr(`ITC_ADDR_TMO, 8'h98);
    @(posedge apb_clk) apb_owner <= 1'b1;
    wt(3, 60, 1);
    chk(n >= 32 && n <= 38, 1);
    test_done;
  end
endmodule : itc_cond_tb
bind itc_cond itc_cond_asserts u_chk (.core_clk(core_clk), .rst(rst), .apb_clk(apb_clk),
  .apb_rst(apb_rst), .sda_pin_in(sda_pin_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_filt(sda_filt), .tgt_busy(tgt_busy), .acc_req(acc_req), .nack(nack),
  .acc_done(acc_done), .acc_timeout(acc_timeout), .owner_timeout(owner_timeout),
  .apb_pready(apb_pready), .apb_start(apb_start));
